// ---- pll_ctrl_regs.svh ----
// register offsets, field positions and reset values of the loop control block
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH
`define ADDR_PLL_CONTROL     8'h89
`define ADDR_PLL_PREDIVIDER  8'h8a
`define ADDR_PLL_MULTIPLIER  8'h8e
`define ADDR_PLL_FILTER      8'h8f
`define RST_PLL_CONTROL      8'h00
`define RST_PLL_PREDIVIDER   8'h01
`define RST_PLL_MULTIPLIER   8'h01
`define RST_PLL_FILTER       8'h31
`define BIT_BIAS_POWER       0
`define BIT_LOOP_ENABLE      1
`define BIT_REF_SOURCE       2
`define BIT_LOCK_STATUS      4
`define MASK_CONTROL_WR      8'h07
`define MASK_PREDIV          8'h1f
`define MASK_FILTER          8'h3f
`define MULT_ZERO_FACTOR     9'h100
`define PREDIV_ZERO_FACTOR   6'h20
`define ZERO_BYTE            8'h00
`endif

// ---- pll_ctrl_pkg.sv ----
// types shared by the loop control block
package pll_ctrl_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [1:0] {
    LOOP_OFF     = 2'b00,
    LOOP_BIASED  = 2'b01,
    LOOP_RUNNING = 2'b10
  } loop_state_type;
endpackage

// ---- pll_ctrl_if.sv ----
// carrier between the register file and the reference path
`timescale 1ns/1ns
interface pll_ctrl_if;
  logic       ref_source_select;  // 0 internal, 1 external
  logic [4:0] prediv_value;       // pre-divider field
  logic [1:0] internal_osc_divide; // internal oscillator divide code
  logic [5:0] prediv_factor;      // effective pre-divide factor
  logic [1:0] ref_route;          // one-hot internal/external route
  modport regs (output ref_source_select, output prediv_value,
                output internal_osc_divide, input prediv_factor, input ref_route);
  modport path (input ref_source_select, input prediv_value,
                input internal_osc_divide, output prediv_factor, output ref_route);
endinterface

// ---- pll_ref_path.sv ----
// reference selection and pre-divide factor decode
`timescale 1ns/1ns
module pll_ref_path
  import pll_ctrl_pkg::*;
(
  // configuration carrier
  pll_ctrl_if.path cfg
);
  `include "pll_ctrl_regs.svh"

  // route: bit 0 internal oscillator, bit 1 external oscillator
  assign cfg.ref_route = cfg.ref_source_select ? 2'b10 : 2'b01;

  // zero pre-divide value treated as 32
  wire [5:0] base_factor = (cfg.prediv_value == 5'h00) ? `PREDIV_ZERO_FACTOR
                                                       : {1'b0, cfg.prediv_value};
  // effective factor handed back to the register file
  assign cfg.prediv_factor = base_factor;
endmodule

// ---- pll_control_registers.sv ----
// special-function registers controlling the on-chip clock multiplier
`timescale 1ns/1ns
//
// Contract
// - lock bit reads loop lock state
// - control bits 7-5 read zero, ignored
// - source bit picks internal or external
// - enable low holds loop in reset
// - bias bit powers bias generator
// - multiplier zero means factor 256
// - filter bits 7-6 read zero, ignored
// - reference divided by pre-divider
// - output equals reference times N over M
// - internal divide applies on internal source
module pll_control_registers
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  // special-function register port
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // analog loop interface
  input  wire logic       LOCK_INDICATOR,
  input  wire logic [1:0] INTERNAL_OSC_DIVIDE,
  output logic            BIAS_POWER_ENABLE,
  output logic            LOOP_RESET,
  output logic      [1:0] REF_ROUTE,
  output logic      [5:0] PREDIV_FACTOR,
  output logic      [8:0] MULT_FACTOR,
  output logic      [1:0] OSCILLATOR_RANGE,
  output logic      [3:0] LOOP_FILTER_RANGE,
  output logic      [1:0] REF_INTERNAL_DIVIDE
);
  `include "pll_ctrl_regs.svh"

  // ==========================================
  // reset release
  logic       rst_meta;   // first reset stage
  logic       rst_n;      // released reset copy

  // two-stage release of the asynchronous reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================
  // helpers
  // multiplier field to factor, zero meaning 256
  function automatic logic [8:0] mult_decode(input byte_type v);
    mult_decode = (v == `ZERO_BYTE) ? `MULT_ZERO_FACTOR : {1'b0, v};
  endfunction

  // ==========================================
  // register storage
  byte_type       ctrl_bits;     // writable control bits 2-0
  byte_type       prediv_reg;    // pre-divider register
  byte_type       mult_reg;      // multiplier register
  byte_type       filter_reg;    // filter register
  logic           lock_status;   // qualified lock flag
  loop_state_type loop_state;    // loop power state
  loop_state_type next_loop_state;

  // write strobes decoded per register
  wire wr_ctrl   = SFR_WR && (SFR_ADDR == `ADDR_PLL_CONTROL);
  wire wr_prediv = SFR_WR && (SFR_ADDR == `ADDR_PLL_PREDIVIDER);
  wire wr_mult   = SFR_WR && (SFR_ADDR == `ADDR_PLL_MULTIPLIER);
  wire wr_filter = SFR_WR && (SFR_ADDR == `ADDR_PLL_FILTER);

  wire bias_on   = ctrl_bits[`BIT_BIAS_POWER];
  wire enable_on = ctrl_bits[`BIT_LOOP_ENABLE];

  // register writes; reserved and unused bits dropped
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_bits  <= `RST_PLL_CONTROL;
      prediv_reg <= `RST_PLL_PREDIVIDER;
      mult_reg   <= `RST_PLL_MULTIPLIER;
      filter_reg <= `RST_PLL_FILTER;
    end else begin
      if (wr_ctrl) begin
        ctrl_bits <= SFR_WDATA & `MASK_CONTROL_WR;
      end
      if (wr_prediv) begin
        prediv_reg <= SFR_WDATA & `MASK_PREDIV;
      end
      if (wr_mult) begin
        mult_reg <= SFR_WDATA;
      end
      if (wr_filter) begin
        filter_reg <= SFR_WDATA & `MASK_FILTER;
      end
    end
  end

  // ==========================================
  // loop state
  // state follows bias and enable bits
  always_comb begin
    unique case ({bias_on, enable_on})
      2'b10:   next_loop_state = LOOP_BIASED;
      2'b11:   next_loop_state = LOOP_RUNNING;
      // enable without bias keeps the loop off
      2'b00, 2'b01: next_loop_state = LOOP_OFF;
    endcase
  end

  // state register and qualified lock flag
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      loop_state  <= LOOP_OFF;
      lock_status <= 1'b0;
    end else begin
      loop_state  <= next_loop_state;
      lock_status <= LOCK_INDICATOR && (next_loop_state == LOOP_RUNNING);
    end
  end

  // ==========================================
  // reference path
  pll_ctrl_if cfg_bus();
  assign cfg_bus.ref_source_select   = ctrl_bits[`BIT_REF_SOURCE];
  assign cfg_bus.prediv_value        = prediv_reg[4:0];
  assign cfg_bus.internal_osc_divide = INTERNAL_OSC_DIVIDE;

  pll_ref_path u_ref_path (
    .cfg (cfg_bus.path)
  );

  // ==========================================
  // read mux
  wire [7:0] ctrl_read = {3'b000, lock_status, 1'b0, ctrl_bits[2:0]};
  wire [7:0] read_mux  = (SFR_ADDR == `ADDR_PLL_CONTROL)    ? ctrl_read  :
                         (SFR_ADDR == `ADDR_PLL_PREDIVIDER) ? prediv_reg :
                         (SFR_ADDR == `ADDR_PLL_MULTIPLIER) ? mult_reg   :
                         (SFR_ADDR == `ADDR_PLL_FILTER)     ? filter_reg : `ZERO_BYTE;

  // registered outputs
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      SFR_RDATA           <= `ZERO_BYTE;
      BIAS_POWER_ENABLE   <= 1'b0;
      LOOP_RESET          <= 1'b1;
      REF_ROUTE           <= 2'b01;
      PREDIV_FACTOR       <= 6'h01;
      MULT_FACTOR         <= 9'h001;
      OSCILLATOR_RANGE    <= 2'b11;
      LOOP_FILTER_RANGE   <= 4'h1;
      REF_INTERNAL_DIVIDE <= 2'b00;
    end else begin
      SFR_RDATA           <= SFR_RD ? read_mux : `ZERO_BYTE;
      BIAS_POWER_ENABLE   <= bias_on;
      LOOP_RESET          <= !(bias_on && enable_on);
      REF_ROUTE           <= cfg_bus.ref_route;
      PREDIV_FACTOR       <= cfg_bus.prediv_factor;
      MULT_FACTOR         <= mult_decode(mult_reg);
      OSCILLATOR_RANGE    <= filter_reg[5:4];
      LOOP_FILTER_RANGE   <= filter_reg[3:0];
      // internal divide passed on only when internal source is routed
      REF_INTERNAL_DIVIDE <= cfg_bus.ref_source_select ? 2'b00
                                                       : cfg_bus.internal_osc_divide;
    end
  end

  // ==========================================
  // checks
  AST_LOCK_QUAL: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !(bias_on && enable_on) |=> !lock_status)
    else $error("lock set while loop not running");
  AST_LOCK_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (bias_on && enable_on && LOCK_INDICATOR) |=> lock_status)
    else $error("lock flag missed");
  AST_CTRL_UPPER: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (SFR_RD && SFR_ADDR == `ADDR_PLL_CONTROL) |=> (SFR_RDATA[7:5] == 3'b000))
    else $error("control upper bits nonzero");
  AST_FILT_UPPER: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (SFR_RD && SFR_ADDR == `ADDR_PLL_FILTER) |=> (SFR_RDATA[7:6] == 2'b00))
    else $error("filter upper bits nonzero");
  AST_MULT_ZERO: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (mult_reg == `ZERO_BYTE) |=> (MULT_FACTOR == `MULT_ZERO_FACTOR))
    else $error("zero multiplier not 256");
  AST_LOOP_RESET: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !enable_on |=> LOOP_RESET)
    else $error("loop released while disabled");
  AST_BIAS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    1'b1 |=> (BIAS_POWER_ENABLE == $past(bias_on)))
    else $error("bias output wrong");
  AST_ROUTE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ctrl_bits[`BIT_REF_SOURCE] |=> (REF_ROUTE == 2'b10))
    else $error("external route not selected");
endmodule

// ---- testbench.sv ----
// self-checking testbench for the loop control special-function registers
`timescale 1ns/1ns
`include "pll_ctrl_regs.svh"
module testbench
  import pll_ctrl_pkg::*;
;
  // ==========================================
  // stimulus and observation signals
  logic       clk_sys, reset_n;          // clock and active-low reset
  logic [7:0] sfr_addr, sfr_wdata;       // register address and write data
  logic       sfr_wr, sfr_rd;            // access strobes
  logic [7:0] sfr_rdata;                 // read data
  logic       lock_indicator;            // raw lock from the loop
  logic [1:0] internal_osc_divide;       // internal oscillator divide code
  logic       bias, loop_reset;          // bias power and loop reset
  logic [1:0] ref_route, osc_range;      // reference route and range code
  logic [5:0] prediv_factor;             // effective pre-divide factor
  logic [8:0] mult_factor;               // effective multiplier
  logic [3:0] filt_range;                // loop filter code
  logic [1:0] int_div;                   // divide code passed to the loop
  int         bad_count, n_compared;     // mismatch and comparison counts
  byte_type   v;                         // loop value
  byte_type   m;                         // masked loop value
  byte_type   vals[6];                   // table of values per test

  pll_control_registers i_pll_control_registers (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
    .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .LOCK_INDICATOR(lock_indicator), .INTERNAL_OSC_DIVIDE(internal_osc_divide),
    .BIAS_POWER_ENABLE(bias), .LOOP_RESET(loop_reset), .REF_ROUTE(ref_route),
    .PREDIV_FACTOR(prediv_factor), .MULT_FACTOR(mult_factor),
    .OSCILLATOR_RANGE(osc_range), .LOOP_FILTER_RANGE(filt_range),
    .REF_INTERNAL_DIVIDE(int_div));

  // ==========================================
  // clock: 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // compare one value, count it and report a mismatch at once
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // write one byte; returns once the value has reached the outputs
  task automatic wr(input byte_type addr, input byte_type data);
    @(negedge clk_sys);
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // read one byte and compare it with the expected value
  task automatic rd_check(input byte_type addr, input byte_type exp);
    @(negedge clk_sys);
    sfr_addr = addr;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    check({1'b0, sfr_rdata}, {1'b0, exp});
  endtask

  // guard against a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  // ==========================================
  // main sequence
  initial begin
    bad_count = 0; n_compared = 0; reset_n = 1'b0; sfr_addr = 8'h00;
    sfr_wdata = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
    lock_indicator = 1'b1; internal_osc_divide = 2'b10;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // reset values, lock masked while the loop is off
    rd_check(`ADDR_PLL_CONTROL, 8'h00);
    rd_check(`ADDR_PLL_MULTIPLIER, 8'h01);
    rd_check(`ADDR_PLL_FILTER, 8'h31);
    rd_check(`ADDR_PLL_PREDIVIDER, 8'h01);
    check(9'(loop_reset), 9'h001);
    check(9'(bias), 9'h000);
    $display("test reset values done");
    // bias on alone: loop still held, lock still masked
    wr(`ADDR_PLL_CONTROL, 8'h01);
    check(9'(bias), 9'h001);
    check(9'(loop_reset), 9'h001);
    rd_check(`ADDR_PLL_CONTROL, 8'h01);
    // settle time of 5 us before the loop is enabled
    repeat (1250) @(negedge clk_sys);
    // unused bits written, reserved bit kept zero: lock reported, external route
    wr(`ADDR_PLL_CONTROL, 8'hf7);
    rd_check(`ADDR_PLL_CONTROL, 8'h17);
    check(9'(loop_reset), 9'h000);
    check(9'(ref_route), 9'h002);
    check(9'(int_div), 9'h000);
    lock_indicator = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd_check(`ADDR_PLL_CONTROL, 8'h07);
    // internal source carries the oscillator divide code
    wr(`ADDR_PLL_CONTROL, 8'h03);
    check(9'(ref_route), 9'h001);
    check(9'(int_div), 9'h002);
    wr(`ADDR_PLL_CONTROL, 8'h00);
    check(9'(loop_reset), 9'h001);
    check(9'(bias), 9'h000);
    $display("test control register done");
    // multiplier, zero meaning 256
    vals = '{8'h00, 8'h01, 8'hff, 8'h80, 8'h14, 8'h14};
    foreach (vals[i]) begin
      v = vals[i];
      wr(`ADDR_PLL_MULTIPLIER, v);
      rd_check(`ADDR_PLL_MULTIPLIER, v);
      check(mult_factor, (v == 8'h00) ? 9'h100 : {1'b0, v});
    end
    $display("test multiplier done");
    // pre-divider, upper bits dropped, zero meaning 32
    vals = '{8'h00, 8'h1f, 8'hff, 8'he0, 8'h05, 8'h01};
    foreach (vals[i]) begin
      v = vals[i];
      m = v & 8'h1f;
      wr(`ADDR_PLL_PREDIVIDER, v);
      rd_check(`ADDR_PLL_PREDIVIDER, m);
      check(9'(prediv_factor), (m == 8'h00) ? 9'h020 : {1'b0, m});
    end
    $display("test pre-divider done");
    // filter codes of every range, upper bits dropped
    vals = '{8'h01, 8'h13, 8'h27, 8'h3f, 8'hff, 8'hc1};
    foreach (vals[i]) begin
      v = vals[i];
      wr(`ADDR_PLL_FILTER, v);
      rd_check(`ADDR_PLL_FILTER, v & 8'h3f);
      check(9'(osc_range), 9'(v[5:4]));
      check(9'(filt_range), 9'(v[3:0]));
    end
    $display("test filter done");
    // unmapped address reads zero and leaves the registers alone
    wr(8'h8b, 8'h5a);
    rd_check(8'h8b, 8'h00);
    rd_check(`ADDR_PLL_MULTIPLIER, 8'h14);
    rd_check(`ADDR_PLL_PREDIVIDER, 8'h01);
    // read data returns to zero once the read strobe is gone
    @(negedge clk_sys);
    check({1'b0, sfr_rdata}, 9'h000);
    $display("test unmapped address done");
    // reset in mid-run: outputs fall back at once, registers reload
    reset_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    check(mult_factor, 9'h001);
    check(9'(prediv_factor), 9'h001);
    check(9'(osc_range), 9'h003);
    check(9'(filt_range), 9'h001);
    check(9'(ref_route), 9'h001);
    check(9'(loop_reset), 9'h001);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd_check(`ADDR_PLL_FILTER, 8'h31);
    rd_check(`ADDR_PLL_MULTIPLIER, 8'h01);
    rd_check(`ADDR_PLL_CONTROL, 8'h00);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
